//--- rtl/sfac_pkg.sv
package sfac_pkg;

	// ==========================================================
	// Command encodings for fuse access
	// ==========================================================
	localparam logic [7:0] OPT_FUSE      = 8'h01;
	localparam logic [7:0] LOC_FUSE_BYTE = 8'hFF;
	localparam logic [7:0] LEN_FUSE      = 8'h00;
	localparam logic [7:0] DATA_FUSE     = 8'h00;
	localparam logic [7:0] LOC_STAGE1    = 8'h06;
	localparam logic [7:0] LOC_STAGE2    = 8'h04;
	localparam logic [7:0] LOC_FINAL     = 8'h00;

	// ==========================================================
	// Fuse stage indices and reset values
	// ==========================================================
	localparam int         STG_FIRST    = 0;
	localparam int         STG_SECOND   = 1;
	localparam int         STG_FINAL    = 2;
	localparam logic [2:0] STAGE_RESET  = 3'h0;
	localparam logic [3:0] FUSE_NIB_DEF = 4'h7;
	localparam logic [3:0] RESERVED_VAL = 4'h0;
	localparam logic [7:0] STATUS_RESET = 8'h00;

	// ==========================================================
	// Configuration memory area boundaries (first byte of area)
	// ==========================================================
	localparam logic [7:0] AREA_RO_LO   = 8'h10;
	localparam logic [7:0] AREA_AC_LO   = 8'h18;
	localparam logic [7:0] AREA_AC_ID   = 8'h20;
	localparam logic [7:0] AREA_CR_LO   = 8'h50;
	localparam logic [7:0] AREA_SE_LO   = 8'h90;
	localparam logic [7:0] AREA_PW_LO   = 8'hB0;
	localparam logic [7:0] AREA_FB_LO   = 8'hF0;
	localparam logic [7:0] LOC_TEST_LO  = 8'h0A;
	localparam logic [7:0] LOC_MAKER_LO = 8'h0C;
	localparam logic [7:0] LOC_HWREV_LO = 8'h0E;

	// ==========================================================
	// Area and permission enumerations
	// ==========================================================
	typedef enum logic [11:0] {
		AR_ANTICOL = 12'h001,
		AR_TEST    = 12'h002,
		AR_MAKER   = 12'h004,
		AR_HWREV   = 12'h008,
		AR_RDONLY  = 12'h010,
		AR_ACCESS  = 12'h020,
		AR_IDOPT   = 12'h040,
		AR_CRYPTO  = 12'h080,
		AR_KEYS    = 12'h100,
		AR_SECRET  = 12'h200,
		AR_PASSWD  = 12'h400,
		AR_COUNTER = 12'h800
	} sfac_area_t;

	typedef enum logic [5:0] {
		PM_OPEN    = 6'h01,
		PM_UNLOCK  = 6'h02,
		PM_UNL_ENC = 6'h04,
		PM_WSECRET = 6'h08,
		PM_FORBID  = 6'h10,
		PM_NONE    = 6'h20
	} sfac_perm_t;

endpackage

//--- rtl/sfac_fuse_bank.sv
module sfac_fuse_bank (
	input  wire logic       clk,
	input  wire logic       resetn,
	input  wire logic [2:0] prog_req,
	output logic      [2:0] blown
);
	import sfac_pkg::*;

	// ==========================================================
	// One-time fuse cells
	// ==========================================================
	// A cell can only move from intact to programmed; there is no
	// path back, so no command can restore a fuse.
	// The reset value stands in for the as-shipped state of the cells.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			blown <= STAGE_RESET;
		end else begin
			blown <= blown | prog_req;
		end
	end

endmodule

//--- rtl/sfac_area_decode.sv
module sfac_area_decode (
	input  wire logic                 variant_two,
	input  wire logic [7:0]           loc,
	output sfac_pkg::sfac_area_t      area,
	output logic                      area_ok,
	output logic      [2:0]           pw_set
);
	import sfac_pkg::*;

	logic [7:0] pw_off;

	// ==========================================================
	// Address to register area
	// ==========================================================
	// Password sets take eight bytes each; counters sit at the
	// first and fifth byte of a set.
	assign pw_off = loc - AREA_PW_LO;
	assign pw_set = pw_off[5:3];

	// Map one location to its area; the top block answers forbidden.
	always_comb begin
		area    = AR_ANTICOL;
		area_ok = 1'b1;
		if (loc >= AREA_FB_LO) begin
			area_ok = 1'b0;
		end else if (loc >= AREA_PW_LO) begin
			area = (pw_off[1:0] == 2'h0) ? AR_COUNTER : AR_PASSWD;
		end else if (loc >= AREA_SE_LO) begin
			area = AR_SECRET;
		end else if (loc >= AREA_CR_LO) begin
			area = loc[3] ? AR_KEYS : AR_CRYPTO;
		end else if (loc >= AREA_AC_LO) begin
			area = (variant_two && loc < AREA_AC_ID) ? AR_IDOPT : AR_ACCESS;
		end else if (loc >= AREA_RO_LO) begin
			area = AR_RDONLY;
		end else if (loc >= LOC_HWREV_LO) begin
			area = variant_two ? AR_HWREV : AR_ANTICOL;
		end else if (loc >= LOC_MAKER_LO) begin
			area = variant_two ? AR_ANTICOL : AR_MAKER;
		end else if (loc >= LOC_TEST_LO) begin
			area = AR_TEST;
		end
	end

endmodule

//--- rtl/sfac_top.sv
module sfac_top #(
	parameter bit VARIANT_TWO = 1'b0
) (
	input  wire logic       clk,
	input  wire logic       resetn,
	input  wire logic       cmd_valid,
	input  wire logic       cmd_write,
	input  wire logic [7:0] cmd_option_field,
	input  wire logic [7:0] cmd_loc,
	input  wire logic [7:0] cmd_len,
	input  wire logic [7:0] cmd_data,
	input  wire logic       unlock_secret_ok,
	input  wire logic       write_secret_ok,
	input  wire logic [2:0] write_secret_set,
	input  wire logic       encrypt_active,
	output logic            rsp_valid,
	output logic            rsp_ack,
	output logic      [7:0] rsp_status,
	output logic            rsp_has_data,
	output logic      [7:0] rsp_data,
	output logic            cfg_rd_go,
	output logic            cfg_wr_go
);
	import sfac_pkg::*;

	// ==========================================================
	// Declarations
	// ==========================================================
	logic [2:0] blown;
	logic [2:0] prog_req;
	logic [2:0] blown_after;
	sfac_area_t area;
	logic       area_ok;
	logic [2:0] pw_set;
	sfac_perm_t perm;
	logic       fuse_cmd;
	logic       fuse_rd;
	logic       fuse_wr;
	logic       fuse_wr_ok;
	logic       granted;
	logic [7:0] fuse_byte_after;
	logic       s1;
	logic       s2;
	logic       fin;

	// ==========================================================
	// Fuse cells and area decode
	// ==========================================================
	sfac_fuse_bank u_bank (
		.clk      (clk),
		.resetn   (resetn),
		.prog_req (prog_req),
		.blown    (blown)
	);

	sfac_area_decode u_dec (
		.variant_two (VARIANT_TWO),
		.loc         (cmd_loc),
		.area        (area),
		.area_ok     (area_ok),
		.pw_set      (pw_set)
	);

	// Logical stage names; the variants share the same programming order.
	assign s1  = blown[STG_FIRST];
	assign s2  = blown[STG_SECOND];
	assign fin = blown[STG_FINAL];

	// ==========================================================
	// Command classification
	// ==========================================================
	// Option 01 selects the fuse byte; anything else is an ordinary
	// configuration access and goes through the permission table.
	assign fuse_cmd = cmd_valid && (cmd_option_field == OPT_FUSE);
	assign fuse_rd  = fuse_cmd && !cmd_write && (cmd_loc == LOC_FUSE_BYTE)
		&& (cmd_len == LEN_FUSE);
	assign fuse_wr  = fuse_cmd && cmd_write && (cmd_len == LEN_FUSE)
		&& (cmd_data == DATA_FUSE);

	// ==========================================================
	// Fuse programming order
	// ==========================================================
	// Each location only programs its fuse when the previous stage is
	// already programmed and this one is still intact.  Repeating a
	// stage is treated as out of order, which keeps the ack honest.
	always_comb begin
		prog_req = 3'h0;
		if (fuse_wr) begin
			unique case (cmd_loc)
				LOC_STAGE1: prog_req[STG_FIRST]  = !s1;
				LOC_STAGE2: prog_req[STG_SECOND] = s1 && !s2;
				LOC_FINAL:  prog_req[STG_FINAL]  = s2 && !fin;
				default:    prog_req = 3'h0;
			endcase
		end
	end

	assign fuse_wr_ok  = |prog_req;
	assign blown_after = blown | prog_req;

	// ==========================================================
	// Fuse status byte
	// ==========================================================
	// The factory fuse is programmed before shipping and is never
	// touched here, so its bit is a constant zero.  Reserved bits are
	// driven to a fixed value; software must not rely on them.
	// Every cell is inverted on the way out, because a programmed
	// fuse must read as 0 and an intact one as 1.
	always_comb begin
		if (VARIANT_TWO) begin
			fuse_byte_after = {
				RESERVED_VAL,
				1'b0,
				~blown_after[STG_FIRST],
				~blown_after[STG_SECOND],
				~blown_after[STG_FINAL]
			};
		end else begin
			fuse_byte_after = {
				RESERVED_VAL,
				1'b0,
				~blown_after[STG_FINAL],
				~blown_after[STG_SECOND],
				~blown_after[STG_FIRST]
			};
		end
	end

	// ==========================================================
	// Permission table, first variant
	// ==========================================================
	function automatic sfac_perm_t perm_one(input sfac_area_t a, input logic wr,
		input logic f1, input logic f2, input logic ff);
		sfac_perm_t p;
		p = PM_OPEN;
		unique case (a)
			AR_ANTICOL: p = !wr ? PM_OPEN : (f1 ? PM_FORBID : PM_UNLOCK);
			AR_TEST:    p = PM_OPEN;
			AR_MAKER:   p = !wr ? PM_OPEN : (f2 ? PM_FORBID : PM_UNLOCK);
			AR_HWREV:   p = !wr ? PM_OPEN : PM_FORBID;
			AR_RDONLY:  p = !wr ? PM_OPEN : PM_FORBID;
			AR_ACCESS,
			AR_IDOPT:   p = !wr ? PM_OPEN : (ff ? PM_FORBID : PM_UNLOCK);
			AR_CRYPTO:  p = !wr ? PM_OPEN : (ff ? PM_FORBID : PM_UNLOCK);
			AR_KEYS,
			AR_SECRET:  p = ff ? PM_FORBID : PM_UNLOCK;
			AR_PASSWD:  p = ff ? PM_WSECRET : PM_UNLOCK;
			AR_COUNTER: p = !wr ? PM_OPEN : (ff ? PM_WSECRET : PM_UNLOCK);
		endcase
		return p;
	endfunction

	// ==========================================================
	// Permission table, second variant
	// ==========================================================
	// The cipher-mode window (first stage only) asks for encryption
	// on every secret-bearing area; later stages drop that demand.
	function automatic sfac_perm_t perm_two(input sfac_area_t a, input logic wr,
		input logic f1, input logic f2, input logic ff);
		sfac_perm_t p;
		sfac_perm_t unl;
		p   = PM_OPEN;
		unl = (f1 && !f2) ? PM_UNL_ENC : PM_UNLOCK;
		unique case (a)
			AR_ANTICOL: p = !wr ? PM_OPEN : (ff ? PM_FORBID : PM_UNLOCK);
			AR_TEST:    p = PM_OPEN;
			AR_MAKER:   p = PM_OPEN;
			AR_HWREV:   p = !wr ? PM_OPEN : PM_FORBID;
			AR_RDONLY:  p = !wr ? PM_OPEN : PM_FORBID;
			AR_ACCESS:  p = !wr ? PM_OPEN : (ff ? PM_FORBID : PM_UNLOCK);
			AR_IDOPT:   p = !wr ? PM_OPEN : (f2 ? PM_FORBID : PM_UNLOCK);
			AR_CRYPTO:  p = !wr ? PM_OPEN : (f2 ? PM_FORBID : PM_UNLOCK);
			AR_KEYS,
			AR_SECRET:  p = f2 ? PM_FORBID : unl;
			AR_PASSWD:  p = ff ? PM_WSECRET : unl;
			AR_COUNTER: p = !wr ? PM_OPEN : (ff ? PM_WSECRET : PM_UNLOCK);
		endcase
		return p;
	endfunction

	// Pick the table of the built variant; the forbidden block always loses.
	always_comb begin
		if (!area_ok) begin
			perm = PM_FORBID;
		end else if (VARIANT_TWO) begin
			perm = perm_two(area, cmd_write, s1, s2, fin);
		end else begin
			perm = perm_one(area, cmd_write, s1, s2, fin);
		end
	end

	// ==========================================================
	// Grant decision
	// ==========================================================
	// The write secret only opens the counter and password bytes of
	// the set that was checked, never a neighbouring set.
	always_comb begin
		granted = 1'b0;
		unique case (perm)
			PM_OPEN:    granted = 1'b1;
			PM_UNLOCK:  granted = unlock_secret_ok;
			PM_UNL_ENC: granted = unlock_secret_ok && encrypt_active;
			PM_WSECRET: granted = write_secret_ok && (write_secret_set == pw_set)
				&& ((area == AR_PASSWD) || (area == AR_COUNTER));
			PM_FORBID:  granted = 1'b0;
			default:    granted = 1'b0;
		endcase
	end

	// ==========================================================
	// Response registers
	// ==========================================================
	// One answer per command, one cycle after it is presented.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rsp_valid <= 1'b0;
		end else begin
			rsp_valid <= cmd_valid;
		end
	end

	// Fuse commands need no secret and answer on their own terms; every
	// other command is acknowledged only when its access is granted.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rsp_ack <= 1'b0;
		end else if (fuse_cmd) begin
			rsp_ack <= fuse_rd || fuse_wr_ok;
		end else begin
			rsp_ack <= cmd_valid && granted;
		end
	end

	// The status byte always carries the fuse byte as it stands after the
	// command, so a programming ack already shows the new fuse.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rsp_status <= STATUS_RESET;
		end else begin
			rsp_status <= fuse_byte_after;
		end
	end

	// The fuse read returns exactly one data byte.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rsp_has_data <= 1'b0;
		end else begin
			rsp_has_data <= fuse_rd;
		end
	end

	// Outside a fuse read the data byte is held at zero, so a stale fuse
	// byte never leaks into the answer of an ordinary command.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rsp_data <= STATUS_RESET;
		end else begin
			rsp_data <= fuse_rd ? fuse_byte_after : STATUS_RESET;
		end
	end

	// ==========================================================
	// Configuration memory strobes
	// ==========================================================
	// Only configuration space is gated here; user zones are checked
	// elsewhere by their own access registers, so no fuse bit leaves
	// this block toward the user memory path.
	// Read strobe: option 01 never reaches configuration memory.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			cfg_rd_go <= 1'b0;
		end else begin
			cfg_rd_go <= cmd_valid && !fuse_cmd && !cmd_write && granted;
		end
	end

	// Write strobe: a refused write must never reach the memory array.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			cfg_wr_go <= 1'b0;
		end else begin
			cfg_wr_go <= cmd_valid && !fuse_cmd && cmd_write && granted;
		end
	end

endmodule

//--- tb/sfac_top_props.sv
module sfac_top_props #(
	parameter bit VARIANT_TWO = 1'b0
) (
	input wire logic       clk,
	input wire logic       resetn,
	input wire logic       cmd_valid,
	input wire logic       cmd_write,
	input wire logic [7:0] cmd_option_field,
	input wire logic [7:0] cmd_loc,
	input wire logic [7:0] cmd_len,
	input wire logic [7:0] cmd_data,
	input wire logic       unlock_secret_ok,
	input wire logic       write_secret_ok,
	input wire logic       rsp_valid,
	input wire logic       rsp_ack,
	input wire logic [7:0] rsp_status,
	input wire logic       rsp_has_data,
	input wire logic [7:0] rsp_data,
	input wire logic       cfg_rd_go,
	input wire logic       cfg_wr_go
);
	timeunit 1ns;
	timeprecision 1ns;

	logic live;
	logic live_d;
	wire  cfg = cmd_valid && cmd_option_field != 8'h01;
	wire  fz  = cmd_valid && cmd_option_field == 8'h01 && cmd_len == 8'h00;

	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);

	// The status byte holds zero in reset, so history checks wait two edges.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			live   <= 1'b0;
			live_d <= 1'b0;
		end else begin
			live   <= 1'b1;
			live_d <= live;
		end
	end

	// ==========================================================
	// Properties
	// ==========================================================
	property p_answer;
		cmd_valid |=> rsp_valid;
	endproperty
	property p_quiet;
		!cmd_valid |=> !rsp_valid && !cfg_rd_go && !cfg_wr_go;
	endproperty
	property p_fuse_read;
		fz && !cmd_write && cmd_loc == 8'hFF |=> rsp_ack && rsp_has_data && rsp_data == rsp_status;
	endproperty
	property p_factory;
		live |-> !rsp_status[3];
	endproperty
	property p_no_revert;
		live_d |-> (rsp_status[2:0] & ~$past(rsp_status[2:0])) == 3'h0;
	endproperty
	property p_change_cause;
		live_d && rsp_status != $past(rsp_status) |->
			rsp_ack && $past(cmd_valid && cmd_write && cmd_option_field == 8'h01);
	endproperty
	property p_first_fuse;
		fz && cmd_write && cmd_loc == 8'h06 && cmd_data == 8'h00 && rsp_status[2:0] == 3'h7
			|=> rsp_ack && rsp_status == (VARIANT_TWO ? 8'h03 : 8'h06);
	endproperty
	property p_forbidden;
		cfg && cmd_loc >= 8'hF0 |=> !rsp_ack && !cfg_rd_go && !cfg_wr_go;
	endproperty
	property p_rdonly;
		cfg && cmd_write && cmd_loc[7:3] == 5'h02 |=> !rsp_ack && !cfg_wr_go;
	endproperty
	property p_unlock;
		cfg && cmd_write && !unlock_secret_ok && !write_secret_ok && cmd_loc inside {[8'h20:8'h4F]}
			|=> !cfg_wr_go;
	endproperty
	property p_test_open;
		cfg && cmd_write && cmd_loc[7:1] == 7'h05 |=> cfg_wr_go && rsp_ack;
	endproperty

	a_answer: assert property (p_answer) else $error("no answer to a command");
	a_quiet: assert property (p_quiet) else $error("answer without a command");
	a_fuse_read: assert property (p_fuse_read) else $error("bad fuse read answer");
	a_factory: assert property (p_factory) else $error("factory fuse reads intact");
	a_no_revert: assert property (p_no_revert) else $error("fuse reverted");
	a_change_cause: assert property (p_change_cause) else $error("fuse change");
	a_first_fuse: assert property (p_first_fuse) else $error("first fuse status");
	a_forbidden: assert property (p_forbidden) else $error("forbidden area granted");
	a_rdonly: assert property (p_rdonly) else $error("read only area written");
	a_unlock: assert property (p_unlock) else $error("write without secret");
	a_test_open: assert property (p_test_open) else $error("test area refused");

	c_fuse_read: cover property (fz && !cmd_write ##1 rsp_has_data);
	c_program: cover property (fz && cmd_write ##1 rsp_ack);
	c_granted: cover property (cfg_wr_go);
endmodule

bind sfac_top sfac_top_props #(.VARIANT_TWO(VARIANT_TWO)) u_props (
	.clk(clk), .resetn(resetn), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
	.cmd_option_field(cmd_option_field), .cmd_loc(cmd_loc), .cmd_len(cmd_len),
	.cmd_data(cmd_data), .unlock_secret_ok(unlock_secret_ok),
	.write_secret_ok(write_secret_ok), .rsp_valid(rsp_valid), .rsp_ack(rsp_ack),
	.rsp_status(rsp_status), .rsp_has_data(rsp_has_data), .rsp_data(rsp_data),
	.cfg_rd_go(cfg_rd_go), .cfg_wr_go(cfg_wr_go)
);

//--- tb/sfac_reader.sv
module sfac_reader (
	input  wire logic       clk,
	output logic            cmd_valid,
	output logic            cmd_write,
	output logic      [7:0] cmd_option_field,
	output logic      [7:0] cmd_loc,
	output logic      [7:0] cmd_len,
	output logic      [7:0] cmd_data
);
	timeunit 1ns;
	timeprecision 1ns;

	// The reader is idle at time zero.
	initial begin
		cmd_valid = 1'b0;
		{cmd_write, cmd_option_field, cmd_loc, cmd_len, cmd_data} = '0;
	end

	// One command frame; outside it the fields show the inverse of the last
	// value, so a design that samples stale fields sees garbage.
	task automatic xfer(input logic w, input logic [7:0] opt, loc, len, dat);
		@(negedge clk);
		cmd_valid        = 1'b1;
		cmd_write        = w;
		cmd_option_field = opt;
		cmd_loc          = loc;
		cmd_len          = len;
		cmd_data         = dat;
		@(negedge clk);
		cmd_valid = 1'b0;
		{cmd_write, cmd_option_field, cmd_loc, cmd_len, cmd_data} =
			~{cmd_write, cmd_option_field, cmd_loc, cmd_len, cmd_data};
	endtask
endmodule

//--- tb/tb_sfac_top.sv
module tb_sfac_top;
	timeunit 1ns;
	timeprecision 1ns;
	import sfac_pkg::*;

	logic       clk, resetn;
	logic       cmd_valid, cmd_write;
	logic [7:0] cmd_option_field, cmd_loc, cmd_len, cmd_data;
	logic       unlock_secret_ok, write_secret_ok;
	logic [2:0] write_secret_set;
	logic       rsp_valid, rsp_ack, rsp_has_data, cfg_rd_go, cfg_wr_go;
	logic [7:0] rsp_status, rsp_data;
	logic       encrypt_active;
	logic       v2_valid, v2_ack, v2_has_data, v2_rd_go, v2_wr_go;
	logic [7:0] v2_status, v2_data;
	int         fails, n_compared, cycles;

	sfac_top u_sfac_top (
		.clk(clk), .resetn(resetn), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
		.cmd_option_field(cmd_option_field), .cmd_loc(cmd_loc), .cmd_len(cmd_len),
		.cmd_data(cmd_data), .unlock_secret_ok(unlock_secret_ok),
		.write_secret_ok(write_secret_ok), .write_secret_set(write_secret_set),
		.encrypt_active(encrypt_active), .rsp_valid(rsp_valid), .rsp_ack(rsp_ack),
		.rsp_status(rsp_status), .rsp_has_data(rsp_has_data), .rsp_data(rsp_data),
		.cfg_rd_go(cfg_rd_go), .cfg_wr_go(cfg_wr_go)
	);

	sfac_reader u_sfac_reader (
		.clk(clk), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
		.cmd_option_field(cmd_option_field), .cmd_loc(cmd_loc),
		.cmd_len(cmd_len), .cmd_data(cmd_data)
	);

	// The second fuse layout sees the same commands as the first.
	if (1) begin : g_two
		sfac_top #(.VARIANT_TWO(1'b1)) u_sfac_top (
			.clk(clk), .resetn(resetn), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
			.cmd_option_field(cmd_option_field), .cmd_loc(cmd_loc), .cmd_len(cmd_len),
			.cmd_data(cmd_data), .unlock_secret_ok(unlock_secret_ok),
			.write_secret_ok(write_secret_ok), .write_secret_set(write_secret_set),
			.encrypt_active(encrypt_active), .rsp_valid(v2_valid), .rsp_ack(v2_ack),
			.rsp_status(v2_status), .rsp_has_data(v2_has_data), .rsp_data(v2_data),
			.cfg_rd_go(v2_rd_go), .cfg_wr_go(v2_wr_go)
		);
	end

	// ==========================================================
	// Checking helpers
	// ==========================================================
	task automatic test_done();
		if (fails == 0 && n_compared > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		n_compared++;
		if (seen !== exp) begin
			fails++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// Expected flags are {ack, has data, read go, write go}.
	task automatic op(input logic w, input logic [7:0] opt, loc, dat,
			input logic u, s, input logic [2:0] set, input logic [3:0] exp);
		unlock_secret_ok = u;
		write_secret_ok  = s;
		write_secret_set = set;
		u_sfac_reader.xfer(w, opt, loc, 8'h00, dat);
		chk({3'h0, rsp_valid, rsp_ack, rsp_has_data, cfg_rd_go, cfg_wr_go},
			{3'h0, 1'b1, exp});
	endtask

	// Clock at 10 MHz.
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	// A hang is cut short well past the roughly 55 cycles the tests need.
	always @(posedge clk) begin
		cycles++;
		if (cycles == 2000) begin
			fails++;
			test_done();
		end
	end

	// ==========================================================
	// Main sequence, both fuse layouts
	// ==========================================================
	initial begin
		resetn = 1'b0;
		{unlock_secret_ok, write_secret_ok, write_secret_set} = '0;
		encrypt_active = 1'b0;
		repeat (2) @(posedge clk);
		@(negedge clk);
		resetn = 1'b1;
		op(0, OPT_FUSE, LOC_FUSE_BYTE, 8'h00, 0, 0, 0, 4'hC);
		chk(rsp_data, 8'h07);
		chk(rsp_status, 8'h07);
		chk(v2_status, 8'h07);
		chk(v2_data, 8'h07);
		op(1, OPT_FUSE, LOC_STAGE2, 8'h00, 0, 0, 0, 4'h0);
		op(1, OPT_FUSE, LOC_STAGE1, 8'h01, 0, 0, 0, 4'h0);
		chk(rsp_status, 8'h07);
		op(1, 8'h00, 8'h00, 8'h5A, 0, 0, 0, 4'h0);
		op(1, 8'h00, 8'h20, 8'h5A, 0, 0, 0, 4'h0);
		op(1, 8'h00, 8'h00, 8'h5A, 1, 0, 0, 4'h9);
		op(1, 8'h00, 8'h0A, 8'h5A, 0, 0, 0, 4'h9);
		op(1, 8'h00, 8'h10, 8'h5A, 1, 0, 0, 4'h0);
		op(0, 8'h00, 8'hF0, 8'h00, 1, 0, 0, 4'h0);
		op(0, 8'h00, 8'h10, 8'h00, 0, 0, 0, 4'hA);
		op(1, OPT_FUSE, LOC_STAGE1, DATA_FUSE, 0, 0, 0, 4'h8);
		chk(rsp_status, 8'h06);
		chk(v2_status, 8'h03);
		op(1, OPT_FUSE, LOC_STAGE1, DATA_FUSE, 0, 0, 0, 4'h0);
		op(1, 8'h00, 8'h00, 8'h5A, 1, 0, 0, 4'h0);
		chk({3'h0, v2_valid, v2_ack, v2_has_data, v2_rd_go, v2_wr_go}, 8'h19);
		op(1, 8'h00, 8'h58, 8'h5A, 1, 0, 0, 4'h9);
		chk({3'h0, v2_valid, v2_ack, v2_has_data, v2_rd_go, v2_wr_go}, 8'h10);
		encrypt_active = 1'b1;
		op(1, 8'h00, 8'h58, 8'h5A, 1, 0, 0, 4'h9);
		chk({3'h0, v2_valid, v2_ack, v2_has_data, v2_rd_go, v2_wr_go}, 8'h19);
		encrypt_active = 1'b0;
		op(1, 8'h00, 8'h0C, 8'h5A, 1, 0, 0, 4'h9);
		op(1, OPT_FUSE, LOC_STAGE2, DATA_FUSE, 0, 0, 0, 4'h8);
		chk(rsp_status, 8'h04);
		chk(v2_status, 8'h01);
		op(1, 8'h00, 8'h0C, 8'h5A, 1, 0, 0, 4'h0);
		op(1, 8'h00, 8'h50, 8'h5A, 1, 0, 0, 4'h9);
		chk({3'h0, v2_valid, v2_ack, v2_has_data, v2_rd_go, v2_wr_go}, 8'h10);
		op(1, OPT_FUSE, LOC_FINAL, DATA_FUSE, 0, 0, 0, 4'h8);
		chk(rsp_status, 8'h00);
		chk(v2_status, 8'h00);
		op(1, 8'h00, 8'h50, 8'h5A, 1, 0, 0, 4'h0);
		op(1, 8'h00, 8'h20, 8'h5A, 1, 0, 0, 4'h0);
		op(1, 8'h00, 8'hB2, 8'h5A, 0, 1, 0, 4'h9);
		op(1, 8'h00, 8'hBA, 8'h5A, 0, 1, 0, 4'h0);
		op(0, 8'h00, 8'hB0, 8'h00, 0, 0, 0, 4'hA);
		op(0, OPT_FUSE, LOC_FUSE_BYTE, 8'h00, 0, 0, 0, 4'hC);
		chk(rsp_data, 8'h00);
		chk(v2_data, 8'h00);
		test_done();
	end
endmodule
